/* File: ddr_self_refresh_exit_seq_tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
`include "dsr_consts.vh"
module ddr_self_refresh_exit_seq_tb_top;
  logic i_clk = 0, i_rst = 1, i_wake = 0, i_isolate = 1, i_pad_save_req = 0;
  logic i_fast_sysclk = 1;
  logic i_pad_override = 0, i_rank1_enable = 0;
  logic [7:0] i_xsr_cycles = `DSR_XSR_CYCLES;
  logic [3:0] i_ac_timing_ctrl_b = 4'h4;
  wire o_clock_enable_rank0, o_clock_enable_rank1, o_chip_select_rank0, o_chip_select_rank1;
  wire o_rank0_ready, o_rank1_ready, o_cke_cfg_err, o_seq_done, v0, v1;
  wire [2:0] o_cmd;
  wire [7:0] o_general_status_reg;
  int err_count = 0, comparisons = 0, tmo = 0, n;
  always #20 i_clk = ~i_clk;
  dsr_self_refresh_exit i_dut (.*);
  dsr_mem_model i_m0 (.i_clk, .i_rst, .i_cke(o_clock_enable_rank0), .i_cmd(o_cmd),
    .i_xsr(i_xsr_cycles), .o_viol(v0));
  dsr_mem_model i_m1 (.i_clk, .i_rst, .i_cke(o_clock_enable_rank1), .i_cmd(o_cmd),
    .i_xsr(i_xsr_cycles), .o_viol(v1));
  task chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  task test_done;
    $display("checks %0d errors %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task cyc(input int k);
    repeat (k) @(posedge i_clk);
  endtask
  always @(posedge i_clk) begin
    tmo <= tmo + 1;
    if (tmo == 3000) begin
      err_count++;
      test_done;
    end
  end
  initial begin
    cyc(4);
    i_rst <= 0;
    cyc(2);
    chk(o_general_status_reg, 32'h0, "status");
    chk(o_cke_cfg_err, 32'h0, "cfg_ok");
    i_pad_save_req <= 1;
    cyc(6);
    i_pad_save_req <= 0;
    cyc(4);
    chk(o_general_status_reg[0], 32'h1, "save_done");
    i_pad_override <= 1;
    i_wake <= 1;
    cyc(40);
    chk(o_clock_enable_rank0, 32'h0, "clock_enable_rank0_isolated");
    chk(o_clock_enable_rank1, 32'h0, "clock_enable_rank1_isolated");
    i_isolate <= 0;
    n = 0;
    while (!o_clock_enable_rank0 && n < 100) begin cyc(1); n++; end
    chk(o_clock_enable_rank1, 32'h1, "clock_enable_rank1_restored");
    n = 0;
    while (!o_rank0_ready && n < 300) begin cyc(1); n++; end
    chk(n, i_xsr_cycles + 1, "exit_delay");
    cyc(20);
    chk(o_rank1_ready, 32'h0, "rank1_gated");
    i_rank1_enable <= 1;
    n = 0;
    while (!o_seq_done && n < 300) begin cyc(1); n++; end
    cyc(1);
    chk(o_rank1_ready, 32'h1, "rank1_ready");
    chk(o_clock_enable_rank1, 32'h1, "clock_enable_rank1");
    chk(v0 | v1, 32'h0, "mem_timing");
    chk(o_chip_select_rank0 | o_chip_select_rank1, 32'h0, "chip_select");
    i_ac_timing_ctrl_b <= 4'hd;
    cyc(2);
    chk(o_cke_cfg_err, 32'h0, "cfg_max");
    i_ac_timing_ctrl_b <= 4'he;
    cyc(2);
    chk(o_cke_cfg_err, 32'h1, "cfg_over");
    i_ac_timing_ctrl_b <= 4'h1;
    cyc(2);
    chk(o_cke_cfg_err, 32'h1, "cfg_under");
    test_done;
  end
endmodule // ddr_self_refresh_exit_seq_tb_top
`default_nettype wire

/* File: dsr_chk_assertions.sv */
`timescale 1ns/10ps
`default_nettype none
`include "dsr_consts.vh"
module dsr_chk #(parameter XSR_W = 8, parameter CKE_W = 4) (
  input wire logic i_clk, i_rst, i_wake, i_isolate, i_fast_sysclk,
  input wire logic i_pad_save_req, i_pad_override, i_rank1_enable,
  input wire logic [XSR_W-1:0] i_xsr_cycles,
  input wire logic [CKE_W-1:0] i_ac_timing_ctrl_b,
  input wire logic o_clock_enable_rank0, o_clock_enable_rank1, o_chip_select_rank0,
  input wire logic o_chip_select_rank1, o_rank0_ready, o_rank1_ready, o_cke_cfg_err,
  input wire logic o_seq_done,
  input wire logic [2:0] o_cmd,
  input wire logic [7:0] o_general_status_reg
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  logic [7:0] hi_cnt_r;
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) hi_cnt_r <= 8'h00;
    else if (!o_clock_enable_rank0) hi_cnt_r <= 8'h00;
    else if (hi_cnt_r != 8'hff) hi_cnt_r <= hi_cnt_r + 8'h01;
  end
  a_no_sr_entry: assert property (o_cmd != `DSR_CMD_SR_ENTRY)
    else $error("entry command issued");
  a_exit_wait: assert property ($rose(o_rank0_ready) |-> hi_cnt_r >= i_xsr_cycles)
    else $error("rank0 ready too early");
  a_rank_order: assert property ($rose(o_rank1_ready) |-> o_rank0_ready && i_rank1_enable)
    else $error("rank1 ready out of order");
  a_iso_hold: assert property (i_isolate && $past(i_isolate, 4) |-> $stable(o_clock_enable_rank1))
    else $error("rank1 clock enable moved");
  a_fast_hold: assert property (i_fast_sysclk && i_isolate && $past(i_isolate, 4)
    |-> $stable(o_clock_enable_rank0)) else $error("rank0 clock enable moved");
  a_save_set: assert property ($rose(i_pad_save_req) |-> ##[1:4] o_general_status_reg[0])
    else $error("save done not set");
  a_save_sticky: assert property (o_general_status_reg[0] |=> o_general_status_reg[0])
    else $error("save done lost");
  a_done_ready: assert property (o_seq_done |-> o_rank0_ready && o_rank1_ready)
    else $error("done before both ranks");
  cover property ($rose(o_rank0_ready));
  cover property ($rose(o_rank1_ready));
  cover property (o_seq_done);
endmodule // dsr_chk
bind dsr_self_refresh_exit dsr_chk #(.XSR_W(XSR_W), .CKE_W(CKE_W)) i_chk (.*);
`default_nettype wire

/* File: dsr_consts.vh */
`ifndef DSR_CONSTS_VH
`define DSR_CONSTS_VH
// clock-enable low period stretch already counted within the programmed field
`define DSR_CKE_EXTRA      4'h2
// default self-refresh exit delay in cycles
`define DSR_XSR_CYCLES     8'h10
// safe pad mode value for the rank1 clock-enable pad entry
`define DSR_SAFE_PAD_MODE  12'h007
`define DSR_PAD_DONE_BIT   0
// command codes on o_cmd
`define DSR_CMD_NOP        3'h0
`define DSR_CMD_SR_EXIT    3'h1
`define DSR_CMD_SR_ENTRY   3'h2
`define DSR_CMD_ACTIVE     3'h3
`endif

/* File: dsr_mem_model.sv */
`timescale 1ns/10ps
`default_nettype none
`include "dsr_consts.vh"
module dsr_mem_model (
  input  wire logic       i_clk, i_rst, i_cke,
  input  wire logic [2:0] i_cmd,
  input  wire logic [7:0] i_xsr,
  output var  logic       o_viol
);
  // rank sits in self refresh while cke is low, never deep power down
  logic [7:0] up_r;
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      up_r <= 8'h00;
      o_viol <= 1'b0;
    end else begin
      up_r <= !i_cke ? 8'h00 : (up_r == 8'hff ? up_r : up_r + 8'h01);
      if (i_cmd == `DSR_CMD_SR_ENTRY || (i_cmd == `DSR_CMD_ACTIVE && up_r < i_xsr))
        o_viol <= 1'b1;
    end
  end
endmodule // dsr_mem_model
`default_nettype wire

/* File: dsr_self_refresh_exit.v */
`timescale 1ns/10ps
`default_nettype none
`include "dsr_consts.vh"

// Overview of operation
// - after a rank's clock-enable rises no command goes to it until the exit delay is over.
// - on wake rank0 leaves self refresh first, then rank1, each on its own clock-enable.
// - the clock-enable low period is the programmed value, which already includes 2 extra cycles.
// - the largest usable minimum pulse is the field maximum less 2, flagged when exceeded.
// - while isolated the rank1 clock-enable pin keeps its value from isolation entry.
// - at isolation release the restored pad setting may drive rank1 clock-enable high early.
// - a save-done bit at bit 0 of the general status is set when the pad save completes.
// - at those clocks the early rank0 toggle does not reach the pin; the rank1 pin stays held by isolation.
// - after wake only rank0 is offered for boot accesses until software enables rank1.
module dsr_self_refresh_exit #(
  parameter XSR_W = 8,
  parameter CKE_W = 4
) (
  // clock and reset
  input  wire             i_clk,
  input  wire             i_rst,
  // power control
  input  wire             i_wake,
  input  wire             i_isolate,
  input  wire             i_fast_sysclk,
  input  wire             i_pad_save_req,
  input  wire             i_pad_override,
  input  wire             i_rank1_enable,
  // timing configuration
  input  wire [XSR_W-1:0] i_xsr_cycles,
  input  wire [CKE_W-1:0] i_ac_timing_ctrl_b,
  // memory side
  output reg              o_clock_enable_rank0,
  output reg              o_clock_enable_rank1,
  output reg              o_chip_select_rank0,
  output reg              o_chip_select_rank1,
  output reg  [2:0]       o_cmd,
  // status
  output reg  [7:0]       o_general_status_reg,
  output reg              o_rank0_ready,
  output reg              o_rank1_ready,
  output reg              o_cke_cfg_err,
  output reg              o_seq_done
);

  // sequencer states
  localparam [2:0] ST_IDLE  = 3'h0;
  localparam [2:0] ST_CLOCK_ENABLE_RANK0  = 3'h1;
  localparam [2:0] ST_WAIT0 = 3'h2;
  localparam [2:0] ST_CLOCK_ENABLE_RANK1  = 3'h3;
  localparam [2:0] ST_WAIT1 = 3'h4;
  localparam [2:0] ST_DONE  = 3'h5;
  // bit positions in the synchroniser vector
  localparam       SY_FAST  = 0;
  localparam       SY_EN1   = 1;
  localparam       SY_OVR   = 2;
  localparam       SY_SAVE  = 3;
  localparam       SY_ISO   = 4;
  localparam       SY_WAKE  = 5;
  localparam       SY_N     = 6;

  wire [SY_N-1:0]  pin_in;
  reg  [SY_N-1:0]  sync1_r;
  reg  [SY_N-1:0]  sync2_r;
  reg              wake_s3_r;
  reg              iso_s3_r;
  reg  [2:0]       state_r;
  reg  [XSR_W-1:0] cnt_r;
  reg  [CKE_W-1:0] low_cnt_r;
  reg              clock_enable_rank1_hold_r;
  wire             wake_sync;
  wire             iso_sync;
  wire             save_sync;
  wire             ovr_sync;
  wire             en1_sync;
  wire             fast_sync;
  wire             wake_rise;
  wire             iso_fall;
  wire [CKE_W-1:0] cke_max;
  wire [CKE_W-1:0] cke_extra;
  genvar           gi;

  assign pin_in    = {i_wake, i_isolate, i_pad_save_req,
                      i_pad_override, i_rank1_enable, i_fast_sysclk};
  assign wake_sync = sync2_r[SY_WAKE];
  assign iso_sync  = sync2_r[SY_ISO];
  assign save_sync = sync2_r[SY_SAVE];
  assign ovr_sync  = sync2_r[SY_OVR];
  assign en1_sync  = sync2_r[SY_EN1];
  assign fast_sync = sync2_r[SY_FAST];
  assign wake_rise = wake_sync & ~wake_s3_r;
  // release seen in the first cycle iso_sync reads low, with the pad restore in that same cycle
  assign iso_fall  = iso_s3_r & ~iso_sync;
  assign cke_max   = {CKE_W{1'b1}};
  assign cke_extra = `DSR_CKE_EXTRA;

  // two flip-flops per pin input before any logic reads it
  generate
    for (gi = 0; gi < SY_N; gi = gi + 1) begin : g_sync
      always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
          sync1_r[gi] <= 1'b0;
          sync2_r[gi] <= 1'b0;
        end else begin
          sync1_r[gi] <= pin_in[gi];
          sync2_r[gi] <= sync1_r[gi];
        end
      end
    end
  endgenerate

  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      wake_s3_r <= 1'b0;
      iso_s3_r  <= 1'b0;
    end else begin
      wake_s3_r <= wake_sync;
      iso_s3_r  <= iso_sync;
    end
  end

  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state_r              <= ST_IDLE;
      cnt_r                <= {XSR_W{1'b0}};
      low_cnt_r            <= {CKE_W{1'b0}};
      clock_enable_rank1_hold_r          <= 1'b0;
      o_clock_enable_rank0 <= 1'b0;
      o_clock_enable_rank1 <= 1'b0;
      o_chip_select_rank0  <= 1'b0;
      o_chip_select_rank1  <= 1'b0;
      o_cmd                <= `DSR_CMD_NOP;
      o_general_status_reg <= 8'h00;
      o_rank0_ready        <= 1'b0;
      o_rank1_ready        <= 1'b0;
      o_cke_cfg_err        <= 1'b0;
      o_seq_done           <= 1'b0;
    end else begin
      o_cmd               <= `DSR_CMD_NOP;
      o_chip_select_rank0 <= 1'b0;
      o_chip_select_rank1 <= 1'b0;
      // save-done sticky until reset
      if (save_sync) begin
        o_general_status_reg[`DSR_PAD_DONE_BIT] <= 1'b1;
      end
      // field must leave room for the stretch
      o_cke_cfg_err <= (i_ac_timing_ctrl_b > cke_max - cke_extra) |
                       (i_ac_timing_ctrl_b < cke_extra);
      // isolation freezes the rank1 pin at its last driven value
      if (iso_sync) begin
        o_clock_enable_rank1 <= clock_enable_rank1_hold_r;
      end else begin
        clock_enable_rank1_hold_r <= o_clock_enable_rank1;
        // restored safe-mode pad drives rank1 high at release
        if (iso_fall && ovr_sync) begin
          o_clock_enable_rank1 <= 1'b1;
        end
      end
      case (state_r)
        ST_IDLE: begin
          if (wake_rise) begin
            o_rank0_ready <= 1'b0;
            o_rank1_ready <= 1'b0;
            o_seq_done    <= 1'b0;
            low_cnt_r     <= i_ac_timing_ctrl_b;
            o_clock_enable_rank0 <= 1'b0;
            state_r       <= ST_CLOCK_ENABLE_RANK0;
          end
        end
        ST_CLOCK_ENABLE_RANK0: begin
          if (low_cnt_r != {CKE_W{1'b0}}) begin
            low_cnt_r <= low_cnt_r - {{(CKE_W-1){1'b0}}, 1'b1};
          end else begin
            // rank0 pin rise masked at fast clocks until isolation clears
            if (!(fast_sync && iso_sync)) begin
              o_clock_enable_rank0 <= 1'b1;
              o_cmd   <= `DSR_CMD_SR_EXIT;
              cnt_r   <= i_xsr_cycles;
              state_r <= ST_WAIT0;
            end
          end
        end
        ST_WAIT0: begin
          if (cnt_r != {XSR_W{1'b0}}) begin
            cnt_r <= cnt_r - {{(XSR_W-1){1'b0}}, 1'b1};
          end else begin
            o_rank0_ready <= 1'b1;
            low_cnt_r     <= i_ac_timing_ctrl_b;
            state_r       <= ST_CLOCK_ENABLE_RANK1;
          end
        end
        ST_CLOCK_ENABLE_RANK1: begin
          if (low_cnt_r != {CKE_W{1'b0}}) begin
            low_cnt_r <= low_cnt_r - {{(CKE_W-1){1'b0}}, 1'b1};
          end else if (!iso_sync) begin
            o_clock_enable_rank1 <= 1'b1;
            o_cmd   <= `DSR_CMD_SR_EXIT;
            cnt_r   <= i_xsr_cycles;
            state_r <= ST_WAIT1;
          end
        end
        ST_WAIT1: begin
          if (cnt_r != {XSR_W{1'b0}}) begin
            cnt_r <= cnt_r - {{(XSR_W-1){1'b0}}, 1'b1};
          end else if (en1_sync) begin
            o_rank1_ready <= 1'b1;
            state_r       <= ST_DONE;
          end
        end
        ST_DONE: begin
          o_seq_done <= 1'b1;
          state_r    <= ST_IDLE;
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

endmodule // dsr_self_refresh_exit
`default_nettype wire
